// file: charger_input_limit_config_regs.svh
// How it works
// - Profile bit 7 at 0 picks the low-voltage battery UVLO and prequal thresholds.
// - Profile bit 7 at 1 picks the typical lithium-ion UVLO and prequal thresholds.
// - Manual selector 01 gives 100mA, 10 gives 500mA, 11 defers to the table field.
// - Table field 000/001/010/110 give 100/500/600/1500mA, 111 reserved, reset 001.
// - With a valid adapter the system floor is 3.4/4.35/4.4/4.5V by code, reset 01.
// - Limit source 0 follows the adapter detect machine, 1 the manual selector.
`ifndef CHARGER_INPUT_LIMIT_CONFIG_REGS_SVH
`define CHARGER_INPUT_LIMIT_CONFIG_REGS_SVH

// Register offsets on the serial bus
`define BUS_CURRENT_CTRL_OFS 8'h0a
`define BATT_THRESH_CTRL_OFS 8'h10

// Reset values
`define BUS_CURRENT_CTRL_RST 8'h24
`define BATT_THRESH_CTRL_RST 8'h00
`define UNMAPPED_READ_VAL 8'h00

// Field positions
`define PROFILE_BIT 7
`define SOURCE_BIT 7

// Manual selector codes
`define MANUAL_100MA 2'h1
`define MANUAL_500MA 2'h2
`define MANUAL_TABLE 2'h3

// Table codes
`define TABLE_100MA 3'h0
`define TABLE_500MA 3'h1
`define TABLE_600MA 3'h2
`define TABLE_1500MA 3'h6

// Current values in mA
`define LIMIT_100_MA 16'h0064
`define LIMIT_500_MA 16'h01f4
`define LIMIT_600_MA 16'h0258
`define LIMIT_1500_MA 16'h05dc

// System floor values in mV
`define VSYS_3400_MV 16'h0d48
`define VSYS_4350_MV 16'h10fe
`define VSYS_4400_MV 16'h1130
`define VSYS_4500_MV 16'h1194

// Device address on the serial bus, value is arbitrary
`define DEV_ADDR_DEFAULT 7'h2a

`endif

// file: charger_input_limit_config_pkg.sv
package charger_input_limit_config_pkg;

  typedef enum logic
  {
    PROFILE_LOW_VOLTAGE = 1'b0,
    PROFILE_TYPICAL_LI_ION = 1'b1
  } battery_profile_t;

  typedef struct packed
  {
    logic bus_limit_source;
    logic [1:0] min_system_voltage;
    logic [2:0] bus_current_table_select;
    logic [1:0] bus_current_manual_select;
  } bus_input_current_control_t;

  typedef struct packed
  {
    logic battery_threshold_profile;
    logic [6:0] reserved;
  } battery_threshold_control_t;

  typedef struct packed
  {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

endpackage : charger_input_limit_config_pkg

// file: serial_reg_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_input_limit_config_regs.svh"
module serial_reg_slave
  import charger_input_limit_config_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output reg_write_t wr_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);

  typedef enum logic [6:0]
  {
    ST_IDLE = 7'b0000001,
    ST_ADDR = 7'b0000010,
    ST_PTR = 7'b0000100,
    ST_WDAT = 7'b0001000,
    ST_ACK = 7'b0010000,
    ST_RDAT = 7'b0100000,
    ST_RACK = 7'b1000000
  } slave_state_t;

  slave_state_t state_r;
  slave_state_t after_ack_r;
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic [7:0] ptr_r;
  logic oe_r;
  logic nack_r;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic byte_done;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[1:0], scl_i};
      sda_sync_r <= {sda_sync_r[1:0], sda_i};
    end
  end

  // Edges judged on stages 1 and 2 only
  assign scl_rise = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall = ~scl_sync_r[1] & scl_sync_r[2];
  assign start_seen = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] &
                      ~sda_sync_r[1];
  assign stop_seen = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] &
                     sda_sync_r[1];
  assign byte_done = (cnt_r == 4'h8);

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine; data changes only after a falling clock edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      after_ack_r <= ST_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      nack_r <= 1'b0;
      wr_o <= '0;
    end
    else
    begin
      wr_o.en <= 1'b0;
      if (start_seen)
      begin
        state_r <= ST_ADDR;
        cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end
      else if (stop_seen)
      begin
        state_r <= ST_IDLE;
        oe_r <= 1'b0;
      end
      else
      begin
        unique case (state_r)
          ST_IDLE:
          begin
            oe_r <= 1'b0;
          end
          ST_ADDR, ST_PTR, ST_WDAT:
          begin
            if (scl_rise)
            begin
              shift_r <= {shift_r[6:0], sda_sync_r[1]};
              cnt_r <= cnt_r + 4'h1;
            end
            else if (scl_fall && byte_done)
            begin
              cnt_r <= 4'h0;
              state_r <= ST_ACK;
              oe_r <= 1'b1;
              if (state_r == ST_ADDR)
              begin
                // Foreign address: stay off the bus until next start
                if (shift_r[7:1] != DEV_ADDR)
                begin
                  state_r <= ST_IDLE;
                  oe_r <= 1'b0;
                end
                after_ack_r <= shift_r[0] ? ST_RDAT : ST_PTR;
              end
              else if (state_r == ST_PTR)
              begin
                ptr_r <= shift_r;
                after_ack_r <= ST_WDAT;
              end
              else
              begin
                wr_o.en <= 1'b1;
                wr_o.addr <= ptr_r;
                wr_o.data <= shift_r;
                ptr_r <= ptr_r + 8'h01;
                after_ack_r <= ST_WDAT;
              end
            end
          end
          ST_ACK:
          begin
            if (scl_fall)
            begin
              state_r <= after_ack_r;
              cnt_r <= 4'h0;
              oe_r <= 1'b0;
              if (after_ack_r == ST_RDAT)
              begin
                shift_r <= rd_data_i;
                oe_r <= ~rd_data_i[7];
              end
            end
          end
          ST_RDAT:
          begin
            if (scl_rise)
            begin
              cnt_r <= cnt_r + 4'h1;
            end
            else if (scl_fall)
            begin
              if (byte_done)
              begin
                state_r <= ST_RACK;
                oe_r <= 1'b0;
                ptr_r <= ptr_r + 8'h01;
              end
              else
              begin
                shift_r <= {shift_r[6:0], 1'b0};
                oe_r <= ~shift_r[6];
              end
            end
          end
          ST_RACK:
          begin
            if (scl_rise)
            begin
              nack_r <= sda_sync_r[1];
            end
            else if (scl_fall)
            begin
              // Master nack ends the read burst
              if (nack_r)
              begin
                state_r <= ST_IDLE;
              end
              else
              begin
                state_r <= ST_RDAT;
                cnt_r <= 4'h0;
                shift_r <= rd_data_i;
                oe_r <= ~rd_data_i[7];
              end
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign rd_addr_o = ptr_r;

endmodule : serial_reg_slave
`default_nettype wire

// file: charger_input_limit_config.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_input_limit_config_regs.svh"
module charger_input_limit_config
  import charger_input_limit_config_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic bus_supply_ok_i,
  input wire logic bat_below_uvlo_i,
  input wire logic adapter_valid_i,
  input wire logic [15:0] adapter_detect_machine_limit_ma_i,
  output battery_profile_t battery_threshold_profile_o,
  output logic [15:0] input_limit_ma_o,
  output logic [15:0] min_system_voltage_mv_o,
  output logic min_sys_reg_en_o,
  output bus_input_current_control_t bus_ctrl_o,
  output battery_threshold_control_t batt_ctrl_o
);

  reg_write_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [1:0] supply_sync_r;
  logic [1:0] uvlo_sync_r;
  logic [1:0] adapter_sync_r;
  logic supply_ok;
  logic bat_low;
  logic adapter_ok;
  logic bus_hold;
  logic batt_hold;
  bus_input_current_control_t bus_ctrl_r;
  battery_threshold_control_t batt_ctrl_r;
  logic [15:0] manual_ma;
  logic [15:0] table_ma;
  logic [15:0] limit_nxt;
  logic [15:0] vsys_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Serial bus register port
  serial_reg_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_o(wr),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Analog status levels cross in through two flops each
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      supply_sync_r <= 2'h0;
      uvlo_sync_r <= 2'h3;
      adapter_sync_r <= 2'h0;
    end
    else
    begin
      supply_sync_r <= {supply_sync_r[0], bus_supply_ok_i};
      uvlo_sync_r <= {uvlo_sync_r[0], bat_below_uvlo_i};
      adapter_sync_r <= {adapter_sync_r[0], adapter_valid_i};
    end
  end

  assign supply_ok = supply_sync_r[1];
  assign bat_low = uvlo_sync_r[1];
  assign adapter_ok = adapter_sync_r[1];

  // Bus-supply loss clears the current register; battery one also needs UVLO
  assign bus_hold = ~supply_ok;
  assign batt_hold = ~supply_ok & bat_low;

  ////////////////////////////////////////////////////////////////////////////
  // Current control register, writable only while bus supply is good
  always_ff @(posedge clk_i)
  begin
    if (rst_i || bus_hold)
    begin
      bus_ctrl_r <= `BUS_CURRENT_CTRL_RST;
    end
    else if (wr.en && wr.addr == `BUS_CURRENT_CTRL_OFS)
    begin
      bus_ctrl_r <= wr.data;
    end
  end

  // Battery register; reserved bits store what software writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i || batt_hold)
    begin
      batt_ctrl_r <= `BATT_THRESH_CTRL_RST;
    end
    else if (wr.en && wr.addr == `BATT_THRESH_CTRL_OFS)
    begin
      batt_ctrl_r <= wr.data;
    end
  end

  // Read mux; unmapped offsets answer zero
  always_comb
  begin
    unique case (rd_addr)
      `BUS_CURRENT_CTRL_OFS: rd_data = bus_ctrl_r;
      `BATT_THRESH_CTRL_OFS: rd_data = batt_ctrl_r;
      default: rd_data = `UNMAPPED_READ_VAL;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table decode; unlisted and reserved codes fall back to 100mA
  always_comb
  begin
    unique case (bus_ctrl_r.bus_current_table_select)
      `TABLE_100MA: table_ma = `LIMIT_100_MA;
      `TABLE_500MA: table_ma = `LIMIT_500_MA;
      `TABLE_600MA: table_ma = `LIMIT_600_MA;
      `TABLE_1500MA: table_ma = `LIMIT_1500_MA;
      default: table_ma = `LIMIT_100_MA;
    endcase
  end

  // Manual selector; code 00 is unlisted, held at the safe 100mA
  always_comb
  begin
    unique case (bus_ctrl_r.bus_current_manual_select)
      `MANUAL_100MA: manual_ma = `LIMIT_100_MA;
      `MANUAL_500MA: manual_ma = `LIMIT_500_MA;
      `MANUAL_TABLE: manual_ma = table_ma;
      default: manual_ma = `LIMIT_100_MA;
    endcase
  end

  // Source choice between detect machine and manual path
  always_comb
  begin
    if (bus_ctrl_r.bus_limit_source)
    begin
      limit_nxt = manual_ma;
    end
    else
    begin
      limit_nxt = adapter_detect_machine_limit_ma_i;
    end
  end

  // System floor voltage by code
  always_comb
  begin
    unique case (bus_ctrl_r.min_system_voltage)
      2'h0: vsys_nxt = `VSYS_3400_MV;
      2'h1: vsys_nxt = `VSYS_4350_MV;
      2'h2: vsys_nxt = `VSYS_4400_MV;
      2'h3: vsys_nxt = `VSYS_4500_MV;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs to the analog loops; limit one clock behind
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      input_limit_ma_o <= `LIMIT_100_MA;
    end
    else
    begin
      input_limit_ma_o <= limit_nxt;
    end
  end

  // Floor code always shown; the enable below gates its use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      min_system_voltage_mv_o <= `VSYS_4350_MV;
    end
    else
    begin
      min_system_voltage_mv_o <= vsys_nxt;
    end
  end

  // Floor regulation only while a valid adapter is seen
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      min_sys_reg_en_o <= 1'b0;
    end
    else
    begin
      min_sys_reg_en_o <= adapter_ok;
    end
  end

  // Low-voltage set at 0, typical Li-ion at 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      battery_threshold_profile_o <= PROFILE_LOW_VOLTAGE;
    end
    else
    begin
      battery_threshold_profile_o <= battery_profile_t'(
        batt_ctrl_r.battery_threshold_profile);
    end
  end

  assign bus_ctrl_o = bus_ctrl_r;
  assign batt_ctrl_o = batt_ctrl_r;

endmodule : charger_input_limit_config
`default_nettype wire

// file: charger_input_limit_config_props.sv
`timescale 1ns/1ps
`default_nettype none
module charger_input_limit_config_props
  import charger_input_limit_config_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_supply_ok_i,
  input wire logic adapter_valid_i,
  input wire logic [15:0] adapter_detect_machine_limit_ma_i,
  input wire battery_profile_t battery_threshold_profile_o,
  input wire logic [15:0] input_limit_ma_o,
  input wire logic [15:0] min_system_voltage_mv_o,
  input wire logic min_sys_reg_en_o,
  input wire bus_input_current_control_t bus_ctrl_o,
  input wire battery_threshold_control_t batt_ctrl_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Table decode; reserved codes fall back to the lowest limit
  function automatic logic [15:0] tbl_ma(input logic [2:0] c);
    case (c)
      3'h1: return 16'h01f4;
      3'h2: return 16'h0258;
      3'h6: return 16'h05dc;
      default: return 16'h0064;
    endcase
  endfunction : tbl_ma

  // System floor decode in mV
  function automatic logic [15:0] vs_mv(input logic [1:0] c);
    case (c)
      2'h0: return 16'h0d48;
      2'h1: return 16'h10fe;
      2'h2: return 16'h1130;
      default: return 16'h1194;
    endcase
  endfunction : vs_mv

  ////////////////////////////////////////////////////////////
  property p_prof_low;
    !batt_ctrl_o.battery_threshold_profile
      |=> battery_threshold_profile_o == PROFILE_LOW_VOLTAGE;
  endproperty
  a_prof_low: assert property (p_prof_low)
    else $error("profile not low-voltage");
  property p_prof_typ;
    batt_ctrl_o.battery_threshold_profile
      |=> battery_threshold_profile_o == PROFILE_TYPICAL_LI_ION;
  endproperty
  a_prof_typ: assert property (p_prof_typ)
    else $error("profile not typical");
  property p_man100;
    bus_ctrl_o.bus_limit_source && bus_ctrl_o.bus_current_manual_select == 2'h1
      |=> input_limit_ma_o == 16'h0064;
  endproperty
  a_man100: assert property (p_man100)
    else $error("manual 100mA wrong");
  property p_man500;
    bus_ctrl_o.bus_limit_source && bus_ctrl_o.bus_current_manual_select == 2'h2
      |=> input_limit_ma_o == 16'h01f4;
  endproperty
  a_man500: assert property (p_man500)
    else $error("manual 500mA wrong");
  property p_tbl;
    bus_ctrl_o.bus_limit_source && bus_ctrl_o.bus_current_manual_select == 2'h3
      |=> input_limit_ma_o ==
        tbl_ma($past(bus_ctrl_o.bus_current_table_select));
  endproperty
  a_tbl: assert property (p_tbl)
    else $error("table limit wrong");
  property p_auto;
    !bus_ctrl_o.bus_limit_source
      |=> input_limit_ma_o == $past(adapter_detect_machine_limit_ma_i);
  endproperty
  a_auto: assert property (p_auto)
    else $error("detect limit not followed");
  property p_vsys;
    min_system_voltage_mv_o == vs_mv($past(bus_ctrl_o.min_system_voltage));
  endproperty
  a_vsys: assert property (p_vsys)
    else $error("system floor wrong");
  property p_en;
    $rose(adapter_valid_i) |-> ##[1:6] min_sys_reg_en_o;
  endproperty
  a_en: assert property (p_en)
    else $error("floor regulation not enabled");
  property p_supply;
    !bus_supply_ok_i [*6] |-> bus_ctrl_o == 8'h24;
  endproperty
  a_supply: assert property (p_supply)
    else $error("current reg not cleared");

  // Main scenarios reached
  c_tbl: cover property (bus_ctrl_o.bus_current_table_select == 3'h6);
  c_auto: cover property (!bus_ctrl_o.bus_limit_source);
  c_en: cover property ($rose(min_sys_reg_en_o));
endmodule : charger_input_limit_config_props

bind charger_input_limit_config charger_input_limit_config_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .bus_supply_ok_i(bus_supply_ok_i),
  .adapter_valid_i(adapter_valid_i),
  .adapter_detect_machine_limit_ma_i(adapter_detect_machine_limit_ma_i),
  .battery_threshold_profile_o(battery_threshold_profile_o),
  .input_limit_ma_o(input_limit_ma_o),
  .min_system_voltage_mv_o(min_system_voltage_mv_o),
  .min_sys_reg_en_o(min_sys_reg_en_o), .bus_ctrl_o(bus_ctrl_o),
  .batt_ctrl_o(batt_ctrl_o)
);
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "charger_input_limit_config_regs.svh"
module testbench
  import charger_input_limit_config_pkg::*;
;
  localparam logic [7:0] DW = {`DEV_ADDR_DEFAULT, 1'b0};
  localparam logic [7:0] BR = `BUS_CURRENT_CTRL_OFS;
  localparam logic [7:0] TR = `BATT_THRESH_CTRL_OFS;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl = 1'b1;
  logic sda_m = 1'b1;
  logic sup = 1'b1;
  logic uvlo = 1'b0;
  logic adp = 1'b0;
  logic [15:0] det = 16'h01f4;
  logic sda_o, oe, en_o;
  battery_profile_t prof;
  logic [15:0] lim, vs;
  bus_input_current_control_t bus_o;
  battery_threshold_control_t bat_o;
  int err_count = 0;
  int total_checks = 0;
  // Open-drain line with pull-up
  wire logic sda = sda_m & ~oe;

  // Free-running clock
  always #2.5 clk_i = ~clk_i;

  charger_input_limit_config DUT (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(oe), .bus_supply_ok_i(sup),
    .bat_below_uvlo_i(uvlo), .adapter_valid_i(adp),
    .adapter_detect_machine_limit_ma_i(det),
    .battery_threshold_profile_o(prof), .input_limit_ma_o(lim),
    .min_system_voltage_mv_o(vs), .min_sys_reg_en_o(en_o),
    .bus_ctrl_o(bus_o), .batt_ctrl_o(bat_o)
  );

  ////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic chk(input string nm, input logic [15:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One bit, sampled mid-high; slow enough for the pin synchronisers
  task automatic bt(input logic b, output logic r);
    sda_m <= b;
    wt(8);
    scl <= 1'b1;
    wt(8);
    r = sda;
    wt(8);
    scl <= 1'b0;
    wt(8);
  endtask : bt
  task automatic by(input logic [7:0] d, input logic am,
                    output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(am, a);
  endtask : by
  task automatic sta();
    sda_m <= 1'b1;
    scl <= 1'b1;
    wt(8);
    sda_m <= 1'b0;
    wt(8);
    scl <= 1'b0;
    wt(8);
  endtask : sta
  task automatic sto();
    sda_m <= 1'b0;
    wt(8);
    scl <= 1'b1;
    wt(8);
    sda_m <= 1'b1;
    wt(16);
  endtask : sto
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic k0, k1, k2;
    sta();
    by(DW, 1'b1, q, k0);
    by(a, 1'b1, q, k1);
    by(d, 1'b1, q, k2);
    sto();
    wt(4);
    chk("write ack", 16'h0000, 16'({k0, k1, k2}));
  endtask : wr
  // Pointer write, repeated start, one byte read with master nack
  task automatic rchk(input string nm, input logic [7:0] a, e);
    logic [7:0] q, d;
    logic k;
    sta();
    by(DW, 1'b1, q, k);
    by(a, 1'b1, q, k);
    sta();
    by(DW | 8'h01, 1'b1, q, k);
    by(8'hff, 1'b1, d, k);
    sto();
    chk(nm, 16'(e), 16'(d));
  endtask : rchk

  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk("bus reg", BR, 8'h24);
    rchk("bat reg", TR, 8'h00);
    rchk("unmapped", 8'h0b, 8'h00);
    chk("auto limit", det, lim);
    chk("vsys", `VSYS_4350_MV, vs);
    chk("floor en", 16'h0000, 16'(en_o));
    chk("sda drive", 16'h0000, 16'(sda_o));
    $display("test reset done");
  endtask : t_reset
  task automatic t_prof();
    wr(TR, 8'h80);
    chk("profile", 16'h0001, 16'(prof));
    rchk("bat reg", TR, 8'h80);
    wr(TR, 8'h00);
    chk("profile", 16'h0000, 16'(prof));
    $display("test profile done");
  endtask : t_prof
  task automatic t_lim();
    logic [2:0] c[4] = '{3'h0, 3'h1, 3'h2, 3'h6};
    logic [15:0] m[4] = '{16'd100, 16'd500, 16'd600, 16'd1500};
    wr(BR, 8'ha1);
    chk("manual limit", 16'd100, lim);
    wr(BR, 8'ha2);
    chk("manual limit", 16'd500, lim);
    for (int i = 0; i < 4; i++)
    begin
      wr(BR, {3'b101, c[i], 2'b11});
      chk("table limit", m[i], lim);
    end
    wr(BR, 8'h23);
    det <= 16'h0123;
    wt(4);
    chk("auto limit", 16'h0123, lim);
    $display("test limit done");
  endtask : t_lim
  task automatic t_vsys();
    logic [15:0] m[4] = '{16'd3400, 16'd4350, 16'd4400, 16'd4500};
    adp <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      wr(BR, {1'b0, 2'(i), 5'h04});
      chk("vsys", m[i], vs);
      chk("floor en", 16'h0001, 16'(en_o));
    end
    $display("test vsys done");
  endtask : t_vsys
  // Supply loss with battery UVLO returns both registers to their reset contents
  task automatic t_sup();
    wr(TR, 8'h80);
    wr(BR, 8'ha2);
    uvlo <= 1'b1;
    sup <= 1'b0;
    wt(10);
    chk("bus reg", 16'h0024, 16'(bus_o));
    chk("bat reg", 16'h0000, 16'(bat_o));
    sup <= 1'b1;
    uvlo <= 1'b0;
    wt(6);
    $display("test supply done");
  endtask : t_sup

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Main sequence after a three-cycle reset
  initial
  begin
    wt(3);
    rst_i <= 1'b0;
    wt(8);
    t_reset();
    t_prof();
    t_lim();
    t_vsys();
    t_sup();
    final_report();
  end

  // Watchdog, about three times the expected run
  initial
  begin
    wt(60000);
    err_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule : testbench
`default_nettype wire
